// *** xrlp_pkg.sv ***
// Overview of operation
// - Each output carries exactly one selected input, and a new selection replaces the old one.
// - One input may feed any number of outputs at once.
// - A connection request changes an output only when it is neither locked nor muted.
// - One command routes a chosen input to every output, each still subject to its lock and mute.
// - Each output has a mute flag, and a muted output presents no signal.
// - Each output has a lock flag, and a locked output refuses every switching request until unlocked.
// - Loading a preset leaves the lock flag and selected input of every locked output untouched.
// - There are 32 preset memories that can be saved from the current state or loaded at any time.
// - A preset holds the routing of all outputs and applies it to every unlocked output on load.
// - Port names hold up to 16 ASCII characters without parentheses or braces, stored in upper case.
// - Preset names follow the same length, character and upper case handling as port names.
// - Port names are kept inside the device so that any controller can read them back.
// - Only one controller session is served at a time, and a second session may not be opened.
// - The device reports its device type and serial number to a controller that asks.
// - The serial control link runs at 9600 baud with eight data bits, one stop bit and no parity.
package xrlp_pkg;
   // ****************************************
   // sizes
   // ****************************************
   localparam int PORTS = 16;
   localparam int SELW = 4;
   localparam int PRESETS = 32;
   localparam int PRW = 5;
   localparam int NAME_LEN = 16;
   localparam int POSW = 4;
   localparam int ENTRIES = 64; // inputs 0-15, outputs 16-31, presets 32-63
   localparam int ENTW = 6;
   // ****************************************
   // register byte addresses
   // ****************************************
   localparam logic [7:0] A_ROUTE = 8'h00;
   localparam logic [7:0] A_ROUTE_ALL = 8'h04;
   localparam logic [7:0] A_MUTE = 8'h08;
   localparam logic [7:0] A_LOCK = 8'h0C;
   localparam logic [7:0] A_PRESET = 8'h10;
   localparam logic [7:0] A_OUT_SEL = 8'h14;
   localparam logic [7:0] A_OUT_STATE = 8'h18;
   localparam logic [7:0] A_NAME_PTR = 8'h1C;
   localparam logic [7:0] A_NAME_DATA = 8'h20;
   localparam logic [7:0] A_DEV_TYPE = 8'h24;
   localparam logic [7:0] A_SERIAL = 8'h28;
   localparam logic [7:0] A_SESSION = 8'h2C;
   localparam logic [7:0] A_LINK_CFG = 8'h30;
   // ****************************************
   // field positions
   // ****************************************
   localparam int F_IDX = 0;  // output, preset or name entry index
   localparam int F_SRC = 8;  // input index for routing
   localparam int F_FLAG = 8; // mute or lock value
   localparam int F_SAVE = 8;
   localparam int F_LOAD = 9;
   localparam int F_POS = 8;  // character position in name pointer
   localparam int F_SESS = 0;
   // ****************************************
   // characters
   // ****************************************
   localparam logic [7:0] CH_LPAR = 8'h28;
   localparam logic [7:0] CH_RPAR = 8'h29;
   localparam logic [7:0] CH_LBRACE = 8'h7B;
   localparam logic [7:0] CH_RBRACE = 8'h7D;
   localparam logic [7:0] CH_LOW_A = 8'h61;
   localparam logic [7:0] CH_LOW_Z = 8'h7A;
   localparam logic [7:0] CH_CASE = 8'h20;
   // ****************************************
   // serial link format
   // ****************************************
   localparam int CLK_HZ = 25000000;
   localparam int BAUD = 9600;
   localparam int BAUD_DIV = CLK_HZ / BAUD;
   localparam int DATA_BITS = 8;
   localparam int STOP_BITS = 1;
   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic lock;
      logic mute;
      logic [SELW-1:0] sel;
   } xrlp_out_s;
   typedef enum {ST_IDLE, ST_FETCH, ST_APPLY} xrlp_st_e;
endpackage : xrlp_pkg

// *** xrlp_presets.sv ***
`timescale 1ns/1ns
`default_nettype none
module xrlp_presets #(
   parameter int NUM = xrlp_pkg::PRESETS,
   parameter int W = xrlp_pkg::PORTS * xrlp_pkg::SELW
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [xrlp_pkg::PRW-1:0] idx,
   input wire logic save,
   input wire logic [W-1:0] wdata,
   output logic [W-1:0] rdata,
   output logic valid
);
   logic [W-1:0] mem [NUM];
   logic [NUM-1:0] valid_q;

   // ****************************************
   // storage, synchronous read
   // ****************************************
   // memory has no reset; valid bits keep unsaved slots from being applied
   always_ff @(posedge clk) begin
      if (save) begin
         mem[idx] <= wdata;
      end
      rdata <= mem[idx];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_q <= '0;
      end else if (save) begin
         valid_q[idx] <= 1'b1;
      end
   end

   assign valid = valid_q[idx];
endmodule : xrlp_presets
`default_nettype wire

// *** xrlp_names.sv ***
`timescale 1ns/1ns
`default_nettype none
module xrlp_names #(
   parameter int ENT = xrlp_pkg::ENTRIES,
   parameter int LEN = xrlp_pkg::NAME_LEN
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ptr_we,
   input wire logic [xrlp_pkg::ENTW-1:0] ptr_ent,
   input wire logic [xrlp_pkg::POSW-1:0] ptr_pos,
   input wire logic ch_we,
   input wire logic [7:0] ch,
   output logic [7:0] rd_ch,
   output logic [xrlp_pkg::ENTW+xrlp_pkg::POSW:0] ptr,
   output logic bad
);
   logic [7:0] mem [ENT*LEN];
   logic [xrlp_pkg::ENTW-1:0] ent_q;
   logic [xrlp_pkg::POSW:0] pos_q;

   // lower-case letters become upper case before storage
   function automatic logic [7:0] to_upper(input logic [7:0] c);
      if (c >= xrlp_pkg::CH_LOW_A && c <= xrlp_pkg::CH_LOW_Z) begin
         return c - xrlp_pkg::CH_CASE;
      end
      return c;
   endfunction : to_upper

   // ****************************************
   // character check and addressing
   // ****************************************
   wire full = pos_q == (xrlp_pkg::POSW+1)'(LEN);
   wire illegal = ch[7] || ch == xrlp_pkg::CH_LPAR || ch == xrlp_pkg::CH_RPAR ||
                  ch == xrlp_pkg::CH_LBRACE || ch == xrlp_pkg::CH_RBRACE;
   wire [xrlp_pkg::ENTW+xrlp_pkg::POSW-1:0] addr = {ent_q, pos_q[xrlp_pkg::POSW-1:0]};
   assign bad = illegal || full;
   assign rd_ch = full ? 8'h00 : mem[addr];
   assign ptr = {ent_q, pos_q};

   // pointer auto-advances after each accepted character
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ent_q <= '0;
         pos_q <= '0;
      end else if (ptr_we) begin
         ent_q <= ptr_ent;
         pos_q <= {1'b0, ptr_pos};
      end else if (ch_we && !bad) begin
         pos_q <= pos_q + 1'b1;
      end
   end

   // names persist across controller sessions; no reset on the array
   always_ff @(posedge clk) begin
      if (ch_we && !bad) begin
         mem[addr] <= to_upper(ch);
      end
   end
endmodule : xrlp_names
`default_nettype wire

// *** xrlp_top.sv ***
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module xrlp_top #(
   parameter logic [31:0] DEV_TYPE = 32'h0000_0A11, // arbitrary value
   parameter logic [31:0] SERIAL_NO = 32'h0000_1234 // arbitrary value
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output var xrlp_pkg::xrlp_out_s [xrlp_pkg::PORTS-1:0] out_state,
   output logic [xrlp_pkg::PORTS-1:0] out_video_en
);
   localparam int PORTS = xrlp_pkg::PORTS;
   localparam int SELW = xrlp_pkg::SELW;
   localparam int RW = PORTS * SELW;

   xrlp_pkg::xrlp_out_s [PORTS-1:0] xp_q, xp_d;
   xrlp_pkg::xrlp_st_e st_q, st_d;
   logic [SELW-1:0] view_q;
   logic sess_q;
   logic [31:0] prdata_q;
   logic err_q;
   logic [31:0] rd_w;
   logic [RW-1:0] cur_route, pre_route;
   logic [2*PORTS-1:0] flags_w;
   logic [RW-1:0] lock_mask;
   logic pre_valid;
   logic name_bad;
   logic [7:0] name_ch;
   logic [xrlp_pkg::ENTW+xrlp_pkg::POSW:0] name_ptr;

   // a route or route-to-all request may switch an output only while it is neither locked nor muted
   function automatic logic can_switch(input xrlp_pkg::xrlp_out_s s);
      return !s.lock && !s.mute;
   endfunction : can_switch

   // ****************************************
   // bus phases and address decode
   // ****************************************
   wire setup = psel && !penable;
   wire access = psel && penable;
   wire wr_done = access && pwrite && pready;
   wire is_route = paddr == xrlp_pkg::A_ROUTE;
   wire is_route_all = paddr == xrlp_pkg::A_ROUTE_ALL;
   wire is_mute = paddr == xrlp_pkg::A_MUTE;
   wire is_lock = paddr == xrlp_pkg::A_LOCK;
   wire is_preset = paddr == xrlp_pkg::A_PRESET;
   wire is_out_sel = paddr == xrlp_pkg::A_OUT_SEL;
   wire is_out_st = paddr == xrlp_pkg::A_OUT_STATE;
   wire is_ptr = paddr == xrlp_pkg::A_NAME_PTR;
   wire is_ndata = paddr == xrlp_pkg::A_NAME_DATA;
   wire is_type = paddr == xrlp_pkg::A_DEV_TYPE;
   wire is_serial = paddr == xrlp_pkg::A_SERIAL;
   wire is_session = paddr == xrlp_pkg::A_SESSION;
   wire is_link = paddr == xrlp_pkg::A_LINK_CFG;
   wire mapped = is_route || is_route_all || is_mute || is_lock || is_preset || is_out_sel ||
                 is_out_st || is_ptr || is_ndata || is_type || is_serial || is_session || is_link;

   // write data fields
   wire [SELW-1:0] w_idx = pwdata[xrlp_pkg::F_IDX +: SELW];
   wire [SELW-1:0] w_src = pwdata[xrlp_pkg::F_SRC +: SELW];
   wire [xrlp_pkg::PRW-1:0] w_pre = pwdata[xrlp_pkg::F_IDX +: xrlp_pkg::PRW];
   wire w_flag = pwdata[xrlp_pkg::F_FLAG];
   wire load_req = pwrite && is_preset && pwdata[xrlp_pkg::F_LOAD];
   wire save_req = pwrite && is_preset && pwdata[xrlp_pkg::F_SAVE];
   wire load_ok = load_req && pre_valid;
   wire claim = pwrite && is_session && pwdata[xrlp_pkg::F_SESS];

   // ****************************************
   // preset and name stores
   // ****************************************
   xrlp_presets #(.NUM(xrlp_pkg::PRESETS), .W(RW)) u_presets (
      .clk(pclk),
      .rst_n(presetn),
      .idx(w_pre),
      .save(wr_done && save_req),
      .wdata(cur_route),
      .rdata(pre_route),
      .valid(pre_valid)
   );

   xrlp_names #(.ENT(xrlp_pkg::ENTRIES), .LEN(xrlp_pkg::NAME_LEN)) u_names (
      .clk(pclk),
      .rst_n(presetn),
      .ptr_we(wr_done && is_ptr),
      .ptr_ent(pwdata[xrlp_pkg::F_IDX +: xrlp_pkg::ENTW]),
      .ptr_pos(pwdata[xrlp_pkg::F_POS +: xrlp_pkg::POSW]),
      .ch_we(wr_done && is_ndata),
      .ch(pwdata[7:0]),
      .rd_ch(name_ch),
      .ptr(name_ptr),
      .bad(name_bad)
   );

   // ****************************************
   // per-output views
   // ****************************************
   for (genvar g = 0; g < PORTS; g++) begin : g_out
      assign cur_route[g*SELW +: SELW] = xp_q[g].sel;
      assign flags_w[2*g +: 2] = {xp_q[g].lock, xp_q[g].mute};
      assign lock_mask[g*SELW +: SELW] = {SELW{xp_q[g].lock}};
      assign out_video_en[g] = !xp_q[g].mute;
   end
   assign out_state = xp_q;

   // ****************************************
   // crosspoint next state
   // ****************************************
   // later commands in the list never meet earlier ones: one write per bus transfer
   always_comb begin
      xp_d = xp_q;
      if (wr_done && is_route && can_switch(xp_q[w_idx])) begin
         xp_d[w_idx].sel = w_src;
      end
      if (wr_done && is_route_all) begin
         for (int i = 0; i < PORTS; i++) begin
            if (can_switch(xp_q[i])) begin
               xp_d[i].sel = w_src;
            end
         end
      end
      if (wr_done && is_mute) begin
         xp_d[w_idx].mute = w_flag;
      end
      if (wr_done && is_lock) begin
         xp_d[w_idx].lock = w_flag;
      end
      if (wr_done && load_ok) begin
         for (int i = 0; i < PORTS; i++) begin
            if (!xp_q[i].lock) begin
               xp_d[i].sel = pre_route[i*SELW +: SELW];
            end
         end
      end
   end

   // ****************************************
   // preset load sequencer
   // ****************************************
   // the preset memory reads synchronously, so a load stretches the access phase
   always_comb begin
      st_d = st_q;
      case (st_q)
         xrlp_pkg::ST_IDLE: begin
            if (access && load_ok) begin
               st_d = xrlp_pkg::ST_FETCH;
            end
         end
         xrlp_pkg::ST_FETCH: begin
            st_d = xrlp_pkg::ST_APPLY;
         end
         xrlp_pkg::ST_APPLY: begin
            st_d = xrlp_pkg::ST_IDLE;
         end
         default: begin
            st_d = xrlp_pkg::ST_IDLE;
         end
      endcase
   end

   assign pready = !load_ok || st_q == xrlp_pkg::ST_APPLY;

   // ****************************************
   // read data and error decode
   // ****************************************
   always_comb begin
      rd_w = '0;
      if (is_out_st) begin
         rd_w = 32'(xp_q[view_q]);
      end else if (is_out_sel) begin
         rd_w = 32'(view_q);
      end else if (is_route || is_route_all) begin
         rd_w = 32'(cur_route); // low outputs only; full map via the state register
      end else if (is_ptr) begin
         rd_w = 32'(name_ptr);
      end else if (is_ndata) begin
         rd_w = 32'(name_ch);
      end else if (is_type) begin
         rd_w = DEV_TYPE;
      end else if (is_serial) begin
         rd_w = SERIAL_NO;
      end else if (is_session) begin
         rd_w = 32'(sess_q);
      end else if (is_link) begin
         rd_w = {8'h00, 4'(xrlp_pkg::STOP_BITS), 4'(xrlp_pkg::DATA_BITS), 16'(xrlp_pkg::BAUD_DIV)};
      end
   end

   wire err_w = !mapped || (pwrite && is_route && !can_switch(xp_q[w_idx])) ||
                (pwrite && is_ndata && name_bad) || (load_req && !pre_valid) ||
                (claim && sess_q);

   assign prdata = prdata_q;
   assign pslverr = access && pready && err_q;

   // ****************************************
   // registers
   // ****************************************
   // read data and error are taken in the setup cycle so the answer leaves a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xp_q <= '0;
         st_q <= xrlp_pkg::ST_IDLE;
         view_q <= '0;
         sess_q <= 1'b0;
         prdata_q <= '0;
         err_q <= 1'b0;
      end else begin
         xp_q <= xp_d;
         st_q <= st_d;
         if (setup) begin
            prdata_q <= rd_w;
            err_q <= err_w;
         end
         if (wr_done && is_out_sel) begin
            view_q <= w_idx;
         end
         if (wr_done && is_session && !err_w) begin
            sess_q <= pwdata[xrlp_pkg::F_SESS];
         end
      end
   end

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   wire [SELW-1:0] pre_sel0 = pre_route[SELW-1:0];

   route_take_a: assert property (
      wr_done && is_route && can_switch(xp_q[w_idx]) |=> xp_q[$past(w_idx)].sel == $past(w_src))
      else $error("route request not applied");

   route_refuse_a: assert property (
      wr_done && is_route && !can_switch(xp_q[w_idx]) |-> pslverr ##1 $stable(cur_route))
      else $error("blocked route changed routing");

   route_all_a: assert property (
      wr_done && is_route_all && can_switch(xp_q[PORTS-1]) |=> xp_q[PORTS-1].sel == $past(w_src))
      else $error("route to all missed an output");

   mute_video_a: assert property (
      wr_done && is_mute && w_flag |=> !out_video_en[$past(w_idx)])
      else $error("muted output still enabled");

   lock_hold_a: assert property (
      wr_done && is_route_all && (|lock_mask) |=> ((cur_route ^ $past(cur_route)) & $past(lock_mask)) == '0)
      else $error("locked output switched");

   load_wait_a: assert property (
      access && load_ok && st_q == xrlp_pkg::ST_IDLE |-> !pready ##1 !pready ##1 pready)
      else $error("preset load timing wrong");

   load_locked_a: assert property (
      wr_done && load_ok && (|lock_mask) |=> ((cur_route ^ $past(cur_route)) & $past(lock_mask)) == '0)
      else $error("preset disturbed locked output");

   load_apply_a: assert property (
      wr_done && load_ok && !xp_q[0].lock |=> xp_q[0].sel == $past(pre_sel0))
      else $error("preset not applied to unlocked output");

   flags_kept_a: assert property (
      !(wr_done && (is_mute || is_lock)) |=> $stable(flags_w))
      else $error("mute or lock changed implicitly");

   session_one_a: assert property (
      wr_done && claim && sess_q |-> pslverr ##1 sess_q)
      else $error("second session accepted");

   // read answers: the word captured in setup must still stand in the access phase
   type_read_a: assert property (
      access && !pwrite && is_type |-> prdata == DEV_TYPE)
      else $error("device type read wrong");

   serial_read_a: assert property (
      access && !pwrite && is_serial |-> prdata == SERIAL_NO)
      else $error("serial number read wrong");

   state_read_a: assert property (
      access && !pwrite && is_out_st |-> prdata == 32'(out_state[view_q]))
      else $error("output state read wrong");

   lock_set_a: assert property (
      wr_done && is_lock |=> out_state[$past(w_idx)].lock == $past(w_flag))
      else $error("lock command not applied");

   session_free_a: assert property (
      wr_done && is_session && !pwdata[xrlp_pkg::F_SESS] |=> !sess_q)
      else $error("session not released");

   name_refuse_a: assert property (
      wr_done && is_ndata && name_bad |-> pslverr ##1 $stable(name_ptr))
      else $error("refused character accepted");
endmodule : xrlp_top
`default_nettype wire

// *** xrlp_host.sv ***
`timescale 1ns/1ns
`default_nettype none
// controller model on the apb side; the chip answers, this side asks
module xrlp_host (
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   // idle bus from time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // one transfer; held until pready is seen at a rising edge, bounded wait
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      while (!ok && n < 16) begin
         @(posedge pclk);
         n++;
         ok = (pready === 1'b1);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d; // released data must not keep showing the last value
      // idle cycle so the next call never re-drives psel in this time step
      @(posedge pclk);
   endtask : xfer
endmodule : xrlp_host
`default_nettype wire

// *** xrlp_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module xrlp_bench;
   localparam logic [31:0] TYPE_ID = 32'h0000_0B22; // arbitrary value
   localparam logic [31:0] SER_ID = 32'h0000_0C33; // arbitrary value
   logic pclk;
   logic presetn;
   wire logic psel, penable, pwrite, pready, pslverr;
   wire logic [7:0] paddr;
   wire logic [31:0] pwdata, prdata;
   xrlp_pkg::xrlp_out_s [xrlp_pkg::PORTS-1:0] st;
   logic [xrlp_pkg::PORTS-1:0] ven;
   logic [31:0] rdv;
   logic errv;
   int n_fail = 0;
   int n_checks = 0;
   xrlp_top #(.DEV_TYPE(TYPE_ID), .SERIAL_NO(SER_ID)) xrlp_top_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .out_state(st), .out_video_en(ven));
   xrlp_host xrlp_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   // 25 mhz
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   // ****************************************
   // checks and bus helpers
   // ****************************************
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [31:0] fld(input int hi, input int lo);
      return 32'((hi << 8) | lo);
   endfunction : fld
   // a hung slave ends the run at once
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic ok;
      xrlp_host_inst.xfer(wr, a, d, rdv, errv, ok);
      if (!ok) begin
         check("pready", 32'h0, 32'h1);
         report_and_stop();
      end
   endtask : bus
   task automatic wr(input string what, input logic [7:0] a, input logic [31:0] d, input logic e);
      bus(1'b1, a, d);
      check(what, 32'(errv), 32'(e));
   endtask : wr
   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000);
      check(what, rdv, e);
   endtask : rd
   task automatic sel_is(input int o, input logic [3:0] s);
      check("sel", 32'(st[o].sel), 32'(s));
   endtask : sel_is
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset;
      for (int i = 0; i < 16; i++)
         check("state", 32'(st[i]), 32'h0);
      check("video", 32'(ven), 32'h0000_FFFF);
      rd("type", xrlp_pkg::A_DEV_TYPE, TYPE_ID);
      rd("serial", xrlp_pkg::A_SERIAL, SER_ID);
      rd("link", xrlp_pkg::A_LINK_CFG, {8'h00, 4'h1, 4'h8, 16'(25000000 / 9600)});
      $display("test reset done");
   endtask : t_reset
   task automatic t_route;
      wr("route", xrlp_pkg::A_ROUTE, fld(3, 0), 1'b0);
      wr("route", xrlp_pkg::A_ROUTE, fld(3, 5), 1'b0);
      wr("route", xrlp_pkg::A_ROUTE, fld(7, 0), 1'b0);
      sel_is(0, 4'h7);
      sel_is(5, 4'h3);
      wr("view", xrlp_pkg::A_OUT_SEL, 32'h0000_0005, 1'b0);
      rd("view", xrlp_pkg::A_OUT_STATE, 32'h0000_0003);
      rd("map", xrlp_pkg::A_ROUTE, 32'h0030_0007);
      $display("test route done");
   endtask : t_route
   // a muted or locked output refuses routing; flags survive routing
   task automatic t_flags;
      wr("route", xrlp_pkg::A_ROUTE, fld(12, 4), 1'b0);
      wr("mute", xrlp_pkg::A_MUTE, fld(1, 2), 1'b0);
      wr("lock", xrlp_pkg::A_LOCK, fld(1, 4), 1'b0);
      check("video", 32'(ven[2]), 32'h0);
      wr("refuse", xrlp_pkg::A_ROUTE, fld(5, 2), 1'b1);
      wr("refuse", xrlp_pkg::A_ROUTE, fld(5, 4), 1'b1);
      sel_is(2, 4'h0);
      sel_is(4, 4'hC);
      wr("all", xrlp_pkg::A_ROUTE_ALL, fld(9, 0), 1'b0);
      for (int i = 0; i < 16; i++)
         sel_is(i, i == 4 ? 4'hC : i == 2 ? 4'h0 : 4'h9);
      check("mute", 32'(st[2].mute), 32'h1);
      check("lock", 32'(st[4].lock), 32'h1);
      wr("unmute", xrlp_pkg::A_MUTE, fld(0, 2), 1'b0);
      check("video", 32'(ven[2]), 32'h1);
      $display("test flags done");
   endtask : t_flags
   // load restores unlocked outputs, even muted ones, and skips locked ones
   task automatic t_preset;
      wr("save", xrlp_pkg::A_PRESET, fld(1, 31), 1'b0);
      wr("empty", xrlp_pkg::A_PRESET, fld(2, 0), 1'b1);
      wr("all", xrlp_pkg::A_ROUTE_ALL, fld(1, 0), 1'b0);
      wr("mute", xrlp_pkg::A_MUTE, fld(1, 6), 1'b0);
      wr("unlock", xrlp_pkg::A_LOCK, fld(0, 4), 1'b0);
      wr("route", xrlp_pkg::A_ROUTE, fld(5, 4), 1'b0);
      wr("lock", xrlp_pkg::A_LOCK, fld(1, 4), 1'b0);
      wr("load", xrlp_pkg::A_PRESET, fld(2, 31), 1'b0);
      for (int i = 0; i < 16; i++)
         sel_is(i, i == 4 ? 4'h5 : i == 2 ? 4'h0 : 4'h9);
      check("lock", 32'(st[4].lock), 32'h1);
      check("mute", 32'(st[6].mute), 32'h1);
      $display("test preset done");
   endtask : t_preset
   task automatic t_names;
      logic [7:0] bad [4] = '{8'h28, 8'h29, 8'h7B, 8'h7D};
      wr("ptr", xrlp_pkg::A_NAME_PTR, fld(0, 16), 1'b0);
      wr("char", xrlp_pkg::A_NAME_DATA, 32'h0000_0061, 1'b0);
      foreach (bad[i])
         wr("bad", xrlp_pkg::A_NAME_DATA, 32'(bad[i]), 1'b1);
      for (int i = 0; i < 15; i++)
         wr("char", xrlp_pkg::A_NAME_DATA, 32'h0000_007A, 1'b0);
      wr("long", xrlp_pkg::A_NAME_DATA, 32'h0000_0041, 1'b1);
      wr("ptr", xrlp_pkg::A_NAME_PTR, fld(1, 16), 1'b0);
      rd("name", xrlp_pkg::A_NAME_DATA, 32'h0000_005A);
      wr("ptr", xrlp_pkg::A_NAME_PTR, fld(0, 16), 1'b0);
      rd("name", xrlp_pkg::A_NAME_DATA, 32'h0000_0041);
      wr("ptr", xrlp_pkg::A_NAME_PTR, fld(0, 63), 1'b0);
      wr("bad", xrlp_pkg::A_NAME_DATA, 32'h0000_007D, 1'b1);
      wr("char", xrlp_pkg::A_NAME_DATA, 32'h0000_0071, 1'b0);
      wr("ptr", xrlp_pkg::A_NAME_PTR, fld(0, 63), 1'b0);
      rd("name", xrlp_pkg::A_NAME_DATA, 32'h0000_0051);
      $display("test names done");
   endtask : t_names
   task automatic t_session;
      wr("claim", xrlp_pkg::A_SESSION, 32'h0000_0001, 1'b0);
      wr("second", xrlp_pkg::A_SESSION, 32'h0000_0001, 1'b1);
      rd("held", xrlp_pkg::A_SESSION, 32'h0000_0001);
      wr("release", xrlp_pkg::A_SESSION, 32'h0000_0000, 1'b0);
      rd("free", xrlp_pkg::A_SESSION, 32'h0000_0000);
      wr("unmapped", 8'h3C, 32'h0000_00FF, 1'b1);
      rd("unmapped", 8'h3C, 32'h0000_0000);
      $display("test session done");
   endtask : t_session
   // reset in mid-run clears routing, flags and preset slots but keeps the stored names
   task automatic t_rerun;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("state", 32'(st[4]), 32'h0);
      check("video", 32'(ven), 32'h0000_FFFF);
      wr("cleared", xrlp_pkg::A_PRESET, fld(2, 31), 1'b1);
      wr("ptr", xrlp_pkg::A_NAME_PTR, fld(0, 63), 1'b0);
      rd("name", xrlp_pkg::A_NAME_DATA, 32'h0000_0051);
      $display("test rerun done");
   endtask : t_rerun
   // reset for 8 cycles, then the scenarios in turn
   initial begin
      presetn = 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_route();
      t_flags();
      t_preset();
      t_names();
      t_session();
      t_rerun();
      report_and_stop();
   end
endmodule : xrlp_bench
`default_nettype wire
